// ### core/fsi_pkg.sv
// constants and register map of the five source interrupt priority block
// Summary of operation
// [R01] - five vectors: two external pins, two timer overflows, one shared serial request
// [R02] - each source has its own enable bit in the enable register
// [R03] - a cleared global enable bit blocks every interrupt; irq_out from status and mask is not gated by it
// [R04] - each source gets one of four levels from its low and upper priority bits
// [R05] - upper priority bits: serial 4, timer1 3, external1 2, timer0 1, external0 0
// [R06] - level is upper:low pair; 00 lowest, 11 highest, mixed pairs in between
// [R07] - upper priority bits 7 to 5 reserved; software never writes them as one
// [R08] - reset clears the five upper priority bits; no single-bit access exists
// [R09] - higher pending level pre-empts lower service; equal levels use fixed polling order
package fsi_pkg;
  localparam int          NSRC           = 5;
  // printed offsets are register indexes; byte address is four times the index
  localparam logic [7:0]  IDX_IRQ_ENABLE = 8'hc0;
  localparam logic [7:0]  IDX_PRIO_LOW   = 8'hc1;
  localparam logic [7:0]  IDX_PRIO_UPPER = 8'hb7;
  localparam logic [7:0]  IDX_EVT_STATUS = 8'hc2;
  localparam logic [7:0]  IDX_EVT_MASK   = 8'hc3;
  localparam logic [7:0]  IDX_SERVICE    = 8'hc4;
  localparam logic [9:0]  ADDR_IRQ_ENABLE = {IDX_IRQ_ENABLE, 2'b00};
  localparam logic [9:0]  ADDR_PRIO_LOW   = {IDX_PRIO_LOW, 2'b00};
  localparam logic [9:0]  ADDR_PRIO_UPPER = {IDX_PRIO_UPPER, 2'b00};
  localparam logic [9:0]  ADDR_EVT_STATUS = {IDX_EVT_STATUS, 2'b00};
  localparam logic [9:0]  ADDR_EVT_MASK   = {IDX_EVT_MASK, 2'b00};
  localparam logic [9:0]  ADDR_SERVICE    = {IDX_SERVICE, 2'b00};
  localparam int          GLOBAL_EN_BIT  = 7;
  localparam int          SRC_EXT0       = 0;
  localparam int          SRC_TMR0       = 1;
  localparam int          SRC_EXT1       = 2;
  localparam int          SRC_TMR1       = 3;
  localparam int          SRC_SER        = 4;
  localparam logic [7:0]  IE_RST         = 8'h00;
  localparam logic [4:0]  PRIO_LOW_RST   = 5'h00;
  localparam logic [4:0]  PRIO_UPPER_RST = 5'h00;
  localparam logic [4:0]  EVT_MASK_RST   = 5'h00;
  localparam logic [1:0]  EXT_IDLE       = 2'h3;
  typedef enum logic [1:0] {
    FSI_BUS_IDLE    = 2'b00,
    FSI_BUS_RD_WAIT = 2'b01,
    FSI_BUS_RD_DONE = 2'b11,
    FSI_BUS_WR      = 2'b10
  } fsi_bus_state_type;
endpackage

// ### core/fsi_sync.sv
// two flip-flop synchroniser for the external request pins
`timescale 1ns/1ps
module fsi_sync #(
  parameter int               W   = 2,
  parameter logic [W-1:0]     RST = '1
) (
  input  wire logic           hclk,
  input  wire logic           hresetn,
  input  wire logic [W-1:0]   d,
  output logic      [W-1:0]   q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } fsi_sync_state_type;

  fsi_sync_state_type st_r, st_nxt;

  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= {RST, RST};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2;
endmodule // fsi_sync

// ### core/fsi_prio_arb.sv
// level and polling order arbiter over the eligible sources
`timescale 1ns/1ps
module fsi_prio_arb
  import fsi_pkg::*;
(
  input  wire logic [fsi_pkg::NSRC-1:0] req,
  input  wire logic [fsi_pkg::NSRC-1:0] hi,
  input  wire logic [fsi_pkg::NSRC-1:0] lo,
  output logic                          any,
  output logic      [2:0]               src,
  output logic      [1:0]               lvl
);
  // highest level first, then lowest source index inside a level
  always_comb begin
    any = 1'b0;
    src = 3'h0;
    lvl = 2'h0;
    for (int l = 3; l >= 0; l--) begin
      for (int i = 0; i < NSRC; i++) begin
        if (!any && req[i] && ({hi[i], lo[i]} == l[1:0])) begin // [R06] [R09]
          any = 1'b1;
          src = i[2:0];
          lvl = l[1:0];
        end
      end
    end
  end
endmodule // fsi_prio_arb

// ### core/fsi_irq_ctrl.sv
// five source interrupt controller with ahb-lite register slave
//
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
module fsi_irq_ctrl
  import fsi_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic        ext_irq0_n,
  input  wire logic        ext_irq1_n,
  input  wire logic        tmr0_ovf,
  input  wire logic        tmr1_ovf,
  input  wire logic        ser_rx_done,
  input  wire logic        ser_tx_done,
  output logic             core_irq_req,
  output logic      [2:0]  core_irq_src,
  output logic      [1:0]  core_irq_lvl,
  input  wire logic        core_irq_ack,
  input  wire logic        core_irq_reti,
  output logic             irq_out
);
  import fsi_pkg::*;

  typedef struct packed {
    fsi_bus_state_type bs;
    logic [9:0]        addr;
    logic              addr_ok;
    logic [31:0]       hrdata;
    logic [7:0]        ie;
    logic [4:0]        pl;
    logic [4:0]        ph;
    logic [4:0]        pend;
    logic [4:0]        stat;
    logic [4:0]        mask;
    logic [1:0]        ext_q;
    logic [3:0]        insvc;
    logic              req;
    logic [2:0]        src;
    logic [1:0]        lvl;
  } fsi_core_state_type;

  fsi_core_state_type st_r, st_nxt;

  logic [1:0] ext_s;
  logic [4:0] evt;
  logic [4:0] elig;
  logic       arb_any;
  logic [2:0] arb_src;
  logic [1:0] arb_lvl;

  // returns {valid, level} of the highest level now in service
  function automatic logic [2:0] top_level(input logic [3:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int l = 0; l < 4; l++) begin
      if (v[l]) begin
        r = {1'b1, l[1:0]};
      end
    end
    return r;
  endfunction

  fsi_sync #(
    .W   (2),
    .RST (EXT_IDLE)
  ) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       ({ext_irq1_n, ext_irq0_n}),
    .q       (ext_s)
  );

  // falling edges on the pins; serial shares one vector for both directions
  assign evt[SRC_EXT0] = st_r.ext_q[0] & ~ext_s[0];  // [R01]
  assign evt[SRC_TMR0] = tmr0_ovf;                    // [R01]
  assign evt[SRC_EXT1] = st_r.ext_q[1] & ~ext_s[1];  // [R01]
  assign evt[SRC_TMR1] = tmr1_ovf;                    // [R01]
  assign evt[SRC_SER]  = ser_rx_done | ser_tx_done;   // [R01]

  assign elig = st_r.pend & st_r.ie[4:0] & {5{st_r.ie[GLOBAL_EN_BIT]}}; // [R02] [R03]

  fsi_prio_arb u_arb (
    .req (elig),
    .hi  (st_r.ph),
    .lo  (st_r.pl),
    .any (arb_any),
    .src (arb_src),
    .lvl (arb_lvl)
  );

  always_comb begin
    logic [2:0] top;
    logic [3:0] svc;
    logic       wr_ok;
    logic [4:0] ack_clr;
    top     = top_level(st_r.insvc);
    svc     = st_r.insvc;
    wr_ok   = (st_r.bs == FSI_BUS_WR) && st_r.addr_ok;
    ack_clr = 5'h00;
    st_nxt  = st_r;
    // bus data phase
    if (wr_ok && st_r.addr == ADDR_IRQ_ENABLE) begin
      st_nxt.ie = hwdata[7:0]; // [R02] [R03]
    end else if (wr_ok && st_r.addr == ADDR_PRIO_LOW) begin
      st_nxt.pl = hwdata[4:0]; // [R04]
    end else if (wr_ok && st_r.addr == ADDR_PRIO_UPPER) begin
      // reserved upper bits are not stored and read back as zero
      st_nxt.ph = hwdata[4:0]; // [R05] [R07]
    end else if (wr_ok && st_r.addr == ADDR_EVT_STATUS) begin
      st_nxt.stat = st_r.stat & ~hwdata[4:0];
    end else if (wr_ok && st_r.addr == ADDR_EVT_MASK) begin
      st_nxt.mask = hwdata[4:0];
    end
    if (st_r.bs == FSI_BUS_RD_WAIT) begin
      st_nxt.hrdata = 32'h0000_0000;
      if (!st_r.addr_ok) begin
        st_nxt.hrdata = 32'h0000_0000;
      end else if (st_r.addr == ADDR_IRQ_ENABLE) begin
        st_nxt.hrdata = {24'h00_0000, st_r.ie};
      end else if (st_r.addr == ADDR_PRIO_LOW) begin
        st_nxt.hrdata = {27'h000_0000, st_r.pl};
      end else if (st_r.addr == ADDR_PRIO_UPPER) begin
        st_nxt.hrdata = {27'h000_0000, st_r.ph}; // [R07]
      end else if (st_r.addr == ADDR_EVT_STATUS) begin
        st_nxt.hrdata = {27'h000_0000, st_r.stat};
      end else if (st_r.addr == ADDR_EVT_MASK) begin
        st_nxt.hrdata = {27'h000_0000, st_r.mask};
      end else if (st_r.addr == ADDR_SERVICE) begin
        st_nxt.hrdata = {22'h00_0000, st_r.insvc, st_r.req, st_r.lvl, st_r.src};
      end
    end
    // bus address phase; reads take one wait state so a write just before is seen
    if (st_r.bs == FSI_BUS_RD_WAIT) begin
      st_nxt.bs = FSI_BUS_RD_DONE;
    end else if (hready && hsel && htrans[1]) begin
      st_nxt.addr    = haddr[9:0];
      st_nxt.addr_ok = (haddr[31:10] == 22'h00_0000);
      st_nxt.bs      = hwrite ? FSI_BUS_WR : FSI_BUS_RD_WAIT;
    end else if (hready) begin
      st_nxt.bs = FSI_BUS_IDLE;
    end
    // service tracking: a return closes the highest level in service
    if (core_irq_reti && top[2]) begin
      svc[top[1:0]] = 1'b0;
    end
    if (core_irq_ack && st_r.req) begin
      svc[st_r.lvl]       = 1'b1;
      ack_clr[st_r.src]   = 1'b1;
    end
    st_nxt.insvc = svc;
    // a new event in the acknowledge cycle keeps its pending bit
    st_nxt.pend  = (st_r.pend & ~ack_clr) | evt;
    st_nxt.stat  = st_nxt.stat | evt;
    st_nxt.ext_q = ext_s;
    // only a level above everything in service may interrupt
    st_nxt.req = arb_any && !(core_irq_ack && st_r.req)
               && (!top[2] || arb_lvl > top[1:0]); // [R09]
    st_nxt.src = arb_src;
    st_nxt.lvl = arb_lvl; // [R04] [R06]
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r         <= '0;
      st_r.bs      <= FSI_BUS_IDLE;
      st_r.ie      <= IE_RST;
      st_r.pl      <= PRIO_LOW_RST;
      st_r.ph      <= PRIO_UPPER_RST; // [R08]
      st_r.mask    <= EVT_MASK_RST;
      st_r.ext_q   <= EXT_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hreadyout    = (st_r.bs != FSI_BUS_RD_WAIT);
  assign hresp        = 1'b0;
  assign hrdata       = st_r.hrdata;
  assign core_irq_req = st_r.req;
  assign core_irq_src = st_r.src;
  assign core_irq_lvl = st_r.lvl;
  assign irq_out      = |(st_r.stat & st_r.mask);

  AST_GLOBAL_OFF: assert property (@(posedge hclk) disable iff (!hresetn) // [R03]
    !st_r.ie[GLOBAL_EN_BIT] |=> !core_irq_req)
    else $error("request raised while global enable was clear");

  AST_SRC_ENABLED: assert property (@(posedge hclk) disable iff (!hresetn) // [R02]
    core_irq_req |-> (($past(elig) >> core_irq_src) & 5'h01) == 5'h01)
    else $error("request for a source that was not enabled and pending");

  AST_LEVEL_PAIR: assert property (@(posedge hclk) disable iff (!hresetn) // [R04]
    core_irq_req |-> ((($past(st_r.ph) >> core_irq_src) & 5'h01) == {4'h0, core_irq_lvl[1]})
                  && ((($past(st_r.pl) >> core_irq_src) & 5'h01) == {4'h0, core_irq_lvl[0]}))
    else $error("request level does not match the priority bits of its source");

  AST_UPPER_WRITE: assert property (@(posedge hclk) disable iff (!hresetn) // [R05]
    (st_r.bs == FSI_BUS_WR && st_r.addr_ok && st_r.addr == ADDR_PRIO_UPPER)
    |=> st_r.ph == $past(hwdata[4:0]))
    else $error("upper priority register did not take the written bits");

  AST_UPPER_RSVD: assert property (@(posedge hclk) disable iff (!hresetn) // [R07]
    (st_r.bs == FSI_BUS_RD_WAIT && st_r.addr == ADDR_PRIO_UPPER)
    |=> hrdata[31:5] == 27'h000_0000 && hreadyout)
    else $error("upper priority read returned reserved bits set");

  AST_UPPER_RESET: assert property (@(posedge hclk) disable iff (!hresetn) // [R08]
    $rose(hresetn) |-> st_r.ph == 5'h00)
    else $error("upper priority bits not clear after reset");

  AST_PREEMPT: assert property (@(posedge hclk) disable iff (!hresetn) // [R09]
    core_irq_req |-> (st_r.insvc >> core_irq_lvl) == 4'h0)
    else $error("request at or below a level already in service");

  AST_EXT_EDGE: assert property (@(posedge hclk) disable iff (!hresetn) // [R01]
    (st_r.ext_q[0] && !ext_s[0]) |=> st_r.pend[SRC_EXT0] && st_r.stat[SRC_EXT0])
    else $error("external request edge did not set pending and status");

  AST_READ_WAIT: assert property (@(posedge hclk) disable iff (!hresetn)
    (hready && hsel && htrans[1] && !hwrite) |=> !hreadyout ##1 hreadyout)
    else $error("read data phase is not exactly one wait state");

  AST_ENABLE_WRITE: assert property (@(posedge hclk) disable iff (!hresetn) // [R02]
    (st_r.bs == FSI_BUS_WR && st_r.addr_ok && st_r.addr == ADDR_IRQ_ENABLE)
    |=> st_r.ie == $past(hwdata[7:0]))
    else $error("enable register did not take the written bits");

  AST_LOW_WRITE: assert property (@(posedge hclk) disable iff (!hresetn) // [R04]
    (st_r.bs == FSI_BUS_WR && st_r.addr_ok && st_r.addr == ADDR_PRIO_LOW)
    |=> st_r.pl == $past(hwdata[4:0]))
    else $error("low priority register did not take the written bits");

  AST_UPPER_HOLD: assert property (@(posedge hclk) disable iff (!hresetn) // [R05]
    !(st_r.bs == FSI_BUS_WR && st_r.addr_ok && st_r.addr == ADDR_PRIO_UPPER)
    |=> $stable(st_r.ph))
    else $error("upper priority bits changed without a write");

  AST_STATUS_SET: assert property (@(posedge hclk) disable iff (!hresetn) // [R01]
    (evt != 5'h00) |=> (st_r.stat & $past(evt)) == $past(evt))
    else $error("event did not set its status bit");

  AST_PEND_SET: assert property (@(posedge hclk) disable iff (!hresetn) // [R01]
    (evt != 5'h00) |=> (st_r.pend & $past(evt)) == $past(evt))
    else $error("event did not set its pending bit");

  AST_EXT1_EDGE: assert property (@(posedge hclk) disable iff (!hresetn) // [R01]
    (st_r.ext_q[1] && !ext_s[1]) |=> st_r.pend[SRC_EXT1] && st_r.stat[SRC_EXT1])
    else $error("second external request edge did not set pending and status");

  AST_TMR1_EVT: assert property (@(posedge hclk) disable iff (!hresetn) // [R01]
    tmr1_ovf |=> st_r.pend[SRC_TMR1])
    else $error("timer1 overflow did not set its pending bit");

  AST_SER_SHARED: assert property (@(posedge hclk) disable iff (!hresetn) // [R01]
    (ser_rx_done || ser_tx_done) |=> st_r.pend[SRC_SER])
    else $error("serial event did not set the shared pending bit");

  AST_NO_REQ_IDLE: assert property (@(posedge hclk) disable iff (!hresetn) // [R02]
    (elig == 5'h00) |=> !core_irq_req)
    else $error("request raised with no eligible source");

  AST_REQ_RISES: assert property (@(posedge hclk) disable iff (!hresetn) // [R09]
    (arb_any && !(core_irq_ack && core_irq_req) && (st_r.insvc >> arb_lvl) == 4'h0)
    |=> core_irq_req && core_irq_src == $past(arb_src))
    else $error("eligible request above all levels in service was not offered");

  AST_ACK_TAKES: assert property (@(posedge hclk) disable iff (!hresetn) // [R09]
    (core_irq_ack && core_irq_req) |=> !core_irq_req && st_r.insvc[$past(core_irq_lvl)])
    else $error("acknowledge did not open service at the offered level");

  AST_ACK_CLEARS: assert property (@(posedge hclk) disable iff (!hresetn) // [R09]
    (core_irq_ack && core_irq_req && !evt[core_irq_src])
    |=> !st_r.pend[$past(core_irq_src)])
    else $error("acknowledge did not clear the pending bit of its source");

  AST_RETI_CLOSE: assert property (@(posedge hclk) disable iff (!hresetn) // [R09]
    (core_irq_reti && !(core_irq_ack && core_irq_req) && st_r.insvc != 4'h0)
    |=> st_r.insvc < $past(st_r.insvc))
    else $error("return did not close a level in service");

  AST_IRQ_OUT: assert property (@(posedge hclk) disable iff (!hresetn)
    ((evt & st_r.mask) != 5'h00 && st_r.bs != FSI_BUS_WR) |=> irq_out)
    else $error("masked-in event did not raise the interrupt output");

  AST_UNMAPPED_READ: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_r.bs == FSI_BUS_RD_WAIT && !st_r.addr_ok) |=> hrdata == 32'h0000_0000)
    else $error("read outside the register window returned data");

  AST_RD_DATA_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_r.bs != FSI_BUS_RD_WAIT) |=> $stable(hrdata))
    else $error("read data changed outside a read data phase");

  COV_REQ_ACK: cover property (@(posedge hclk) disable iff (!hresetn)
    core_irq_req && core_irq_ack);
  COV_NESTED: cover property (@(posedge hclk) disable iff (!hresetn)
    core_irq_req && st_r.insvc != 4'h0);
  COV_RETI: cover property (@(posedge hclk) disable iff (!hresetn)
    core_irq_reti && st_r.insvc != 4'h0);
  COV_IRQ_OUT: cover property (@(posedge hclk) disable iff (!hresetn) $rose(irq_out));
  COV_PREEMPT: cover property (@(posedge hclk) disable iff (!hresetn)
    $rose(core_irq_req) && st_r.insvc != 4'h0);
endmodule // fsi_irq_ctrl

// ### bench/fsi_core_model.sv
// processor core model that takes offered vectors and returns from them
`timescale 1ns/1ps
module fsi_core_model (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       core_irq_req,
  input  wire logic [2:0] core_irq_src,
  input  wire logic [1:0] core_irq_lvl,
  input  wire logic [3:0] dly,
  output logic            core_irq_ack,
  output logic            core_irq_reti,
  output logic      [2:0] taken_src,
  output logic      [1:0] taken_lvl,
  output logic      [7:0] taken_n
);
  logic       busy;
  logic [3:0] w;
  // one vector at a time: nested service is left to the design's own checks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {core_irq_ack, core_irq_reti, taken_src, taken_lvl, taken_n, busy, w} <= '0;
    end else begin
      core_irq_ack  <= 1'b0;
      core_irq_reti <= 1'b0;
      if (core_irq_ack) begin
        taken_src <= core_irq_src;
        taken_lvl <= core_irq_lvl;
        taken_n   <= taken_n + 8'h01;
        busy      <= 1'b1;
        w         <= 4'h0;
      end else if (busy) begin
        w <= w + 4'h1;
        // service stays open long enough for a higher request to show meanwhile
        if (w == 4'h9) begin
          core_irq_reti <= 1'b1;
          busy          <= 1'b0;
          w             <= 4'h0;
        end
      end else if (core_irq_req && w >= dly) begin
        core_irq_ack <= 1'b1;
      end else begin
        w <= core_irq_req ? w + 4'h1 : 4'h0;
      end
    end
  end
endmodule // fsi_core_model

// ### bench/fsi_irq_ctrl_tb_top.sv
// register and vector tests of the five source interrupt controller
`timescale 1ns/1ps
module fsi_irq_ctrl_tb_top;
  import fsi_pkg::*;
  logic        hclk    = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel    = 1'b0;
  logic        hwrite  = 1'b0;
  logic [1:0]  htrans  = 2'h0;
  logic [31:0] haddr   = 32'h0;
  logic [31:0] hwdata  = 32'h0;
  logic [1:0]  ext_n   = 2'h3;
  logic [2:0]  pul     = 3'h0;
  logic        tx      = 1'b0;
  logic [3:0]  dly     = 4'h0;
  logic [31:0] hrdata, rd;
  logic        hreadyout, hresp, req, ack, reti, irq_out;
  logic [2:0]  src, tsrc;
  logic [1:0]  lvl, tlvl;
  logic [7:0]  tn, ntk;
  int          fails = 0;
  int          samples_checked = 0;
  localparam logic [9:0] AD [7] = '{ADDR_IRQ_ENABLE, ADDR_PRIO_LOW, ADDR_PRIO_UPPER,
    ADDR_EVT_STATUS, ADDR_EVT_MASK, ADDR_SERVICE, 10'h3fc};

  fsi_irq_ctrl uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ext_irq0_n(ext_n[0]),
    .ext_irq1_n(ext_n[1]), .tmr0_ovf(pul[0]), .tmr1_ovf(pul[1]), .ser_rx_done(pul[2]),
    .ser_tx_done(tx), .core_irq_req(req), .core_irq_src(src), .core_irq_lvl(lvl),
    .core_irq_ack(ack), .core_irq_reti(reti), .irq_out(irq_out));
  fsi_core_model core (.hclk(hclk), .hresetn(hresetn), .core_irq_req(req),
    .core_irq_src(src), .core_irq_lvl(lvl), .dly(dly), .core_irq_ack(ack),
    .core_irq_reti(reti), .taken_src(tsrc), .taken_lvl(tlvl), .taken_n(tn));

  always #10 hclk = ~hclk;

  task automatic complete_run;
    $display("checks %0d errors %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // address phase held until hready, then data phase held until hready again
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rchk(input string nm, input logic [9:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask

  // m holds {tx, serial rx, timer1, ext1, timer0, ext0}, one cycle wide
  task automatic fire(input logic [5:0] m);
    @(posedge hclk);
    ext_n <= ~{m[2], m[0]};
    pul <= {m[4], m[3], m[1]};
    tx <= m[5];
    @(posedge hclk);
    ext_n <= 2'h3;
    pul <= 3'h0;
    tx <= 1'b0;
  endtask

  task automatic take(input logic [2:0] s, input logic [1:0] l);
    for (int i = 0; i < 80 && tn == ntk; i++) @(posedge hclk);
    ntk = ntk + 8'h01;
    chk("vector count", {24'h0, ntk}, {24'h0, tn});
    chk("vector src", {29'h0, s}, {29'h0, tsrc});
    chk("vector lvl", {30'h0, l}, {30'h0, tlvl});
  endtask

  initial begin
    repeat (20000) @(posedge hclk);
    fails++;
    complete_run;
  end

  initial begin
    ntk = 8'h00;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 7; i++) rchk("reset value", AD[i], 32'h0);
    bus(1'b1, ADDR_IRQ_ENABLE, 32'h9f);
    rchk("enable", ADDR_IRQ_ENABLE, 32'h9f);
    bus(1'b1, ADDR_PRIO_UPPER, 32'h18);
    bus(1'b1, ADDR_PRIO_LOW, 32'h0a);
    rchk("upper prio", ADDR_PRIO_UPPER, 32'h18);
    bus(1'b1, 10'h3fc, 32'hff);
    rchk("unmapped", 10'h3fc, 32'h0);
    chk("hresp", 32'h0, {31'h0, hresp});
    // timer1 at 11, serial at 10, timer0 at 01 fired together
    dly <= 4'h3;
    fire(6'h1a);
    take(3'd3, 2'd3);
    take(3'd4, 2'd2);
    take(3'd1, 2'd1);
    dly <= 4'h0;
    bus(1'b1, ADDR_PRIO_UPPER, 32'h0);
    bus(1'b1, ADDR_PRIO_LOW, 32'h0);
    fire(6'h1a);
    take(3'd1, 2'd0);
    take(3'd3, 2'd0);
    take(3'd4, 2'd0);
    for (int s = 0; s < 5; s++) begin
      fire(6'(1 << s));
      take(3'(s), 2'd0);
    end
    fire(6'h20);
    take(3'd4, 2'd0);
    // timer1 at level 01 arrives while timer0 at level 00 is still in service
    bus(1'b1, ADDR_PRIO_LOW, 32'h08);
    fire(6'h02);
    take(3'd1, 2'd0);
    fire(6'h08);
    rchk("nested req", ADDR_SERVICE, 32'h6b);
    take(3'd3, 2'd1);
    bus(1'b1, ADDR_IRQ_ENABLE, 32'h1f);
    fire(6'h02);
    repeat (20) @(posedge hclk);
    chk("req no global", 32'h0, {31'h0, req});
    bus(1'b1, ADDR_IRQ_ENABLE, 32'h9d);
    repeat (20) @(posedge hclk);
    chk("req src off", 32'h0, {31'h0, req});
    bus(1'b1, ADDR_IRQ_ENABLE, 32'h9f);
    take(3'd1, 2'd0);
    rchk("status", ADDR_EVT_STATUS, 32'h1f);
    bus(1'b1, ADDR_EVT_MASK, 32'h02);
    @(negedge hclk);
    chk("irq masked in", 32'h1, {31'h0, irq_out});
    bus(1'b1, ADDR_EVT_STATUS, 32'h02);
    @(negedge hclk);
    chk("irq cleared", 32'h0, {31'h0, irq_out});
    rchk("status", ADDR_EVT_STATUS, 32'h1d);
    complete_run;
  end
endmodule // fsi_irq_ctrl_tb_top
